// ==== rtl/t4x_map.svh ====
// Opcodes, field positions and reset values for the timer 4 transfer executor
`ifndef T4X_MAP_SVH
`define T4X_MAP_SVH

`define T4X_INSTR_W        10
`define T4X_OP_LOAD_TLR    10'h233
`define T4X_OP_LOAD_HR     10'h237
`define T4X_OP_COPY_LR_T   10'h297
`define T4X_OP_COPY_B_A    10'h01e

`define T4X_HI_NIB_MSB     7
`define T4X_HI_NIB_LSB     4
`define T4X_LO_NIB_MSB     3
`define T4X_LO_NIB_LSB     0

`define T4X_TIMER_RST      8'h00
`define T4X_RELOAD_RST     8'h00
`define T4X_NIB_RST        4'h0

`define T4X_INSTR_WORDS    1
`define T4X_INSTR_CYCLES   1

`endif

// ==== rtl/t4x_pkg.sv ====
// Types shared by the timer 4 transfer executor
package t4x_pkg;

	typedef enum logic [2:0] {
		T4X_NONE,
		T4X_LOAD_TIMER_AND_LOW_RELOAD,
		T4X_LOAD_HIGH_RELOAD,
		T4X_COPY_LOW_RELOAD_TO_TIMER,
		T4X_COPY_AUX_TO_ACC
	} t4x_op_t;

endpackage

// ==== rtl/t4x_decode.sv ====
// Opcode decoder for the timer 4 transfer instructions
`timescale 1ns/10ps
`include "t4x_map.svh"

module t4x_decode
	import t4x_pkg::*;
(
	// Fetched instruction
	input  wire logic                     instr_valid,
	input  wire logic [`T4X_INSTR_W-1:0]  instr,
	// Decoded operation
	output t4x_op_t                       op
);

	always_comb begin
		op = T4X_NONE;
		if (instr_valid) begin
			case (instr)
				`T4X_OP_LOAD_TLR:  op = T4X_LOAD_TIMER_AND_LOW_RELOAD;
				`T4X_OP_LOAD_HR:   op = T4X_LOAD_HIGH_RELOAD;
				`T4X_OP_COPY_LR_T: op = T4X_COPY_LOW_RELOAD_TO_TIMER;
				`T4X_OP_COPY_B_A:  op = T4X_COPY_AUX_TO_ACC;
				default:           op = T4X_NONE;
			endcase
		end
	end

endmodule

// ==== rtl/t4x_exec.sv ====
// Timer 4 and reload register transfer instruction executor
// Notes on behaviour
// [RL1] Combined load puts auxiliary register into high nibble of timer and low reload.
// [RL2] Combined load puts accumulator into low nibble of timer and low reload.
// [RL3] High reload load takes auxiliary high nibble and accumulator low nibble.
// [RL4] Reload-to-timer copies all eight low reload bits into timer, reload unchanged.
// [RL5] Register transfer copies auxiliary register into accumulator, auxiliary unchanged.
// [RL6] Each is one word, one cycle, carry untouched, never skips next.
`timescale 1ns/10ps
`include "t4x_map.svh"

module t4x_exec
	import t4x_pkg::*;
#(
	parameter int TIMER_W = 8,
	parameter int NIB_W   = 4
)(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// Instruction from the sequencer
	input  wire logic                     instr_valid,
	input  wire logic [`T4X_INSTR_W-1:0]  instr,
	// CPU registers
	input  wire logic [NIB_W-1:0]         acc,
	input  wire logic [NIB_W-1:0]         aux_b,
	input  wire logic                     carry_flag,
	// Accumulator write back
	output logic                          acc_we_q,
	output logic [NIB_W-1:0]              acc_wdata_q,
	// Timer 4 state
	output logic [TIMER_W-1:0]            timer4_q,
	output logic [TIMER_W-1:0]            timer4_low_reload_q,
	output logic [TIMER_W-1:0]            timer4_high_reload_q,
	output logic                          timer4_loaded_q,
	// Sequencer status
	output logic                          done_q,
	output logic                          skip_next_q,
	output logic                          carry_we_q
);

	// The nibble placement only works for two four-bit halves
	if (TIMER_W != 2 * NIB_W || NIB_W != 4) begin : g_width_check
		$error("t4x_exec: TIMER_W must be twice NIB_W and NIB_W must be 4");
	end

	t4x_op_t op;

	logic [TIMER_W-1:0] timer4_d;
	logic [TIMER_W-1:0] timer4_low_reload_d;
	logic [TIMER_W-1:0] timer4_high_reload_d;
	logic               timer4_loaded_d;
	logic               acc_we_d;
	logic [NIB_W-1:0]   acc_wdata_d;
	logic               done_d;

	t4x_decode u_decode (
		.instr_valid (instr_valid),
		.instr       (instr),
		.op          (op)
	);

	// Unrecognised words leave every register as it stands, except the done, load and write strobes, which drop
	always_comb begin
		timer4_d             = timer4_q;
		timer4_low_reload_d  = timer4_low_reload_q;
		timer4_high_reload_d = timer4_high_reload_q;
		timer4_loaded_d      = 1'b0;
		acc_we_d             = 1'b0;
		acc_wdata_d          = acc_wdata_q;
		done_d               = (op != T4X_NONE);
		case (op)
			T4X_LOAD_TIMER_AND_LOW_RELOAD: begin
				timer4_d[`T4X_HI_NIB_MSB:`T4X_HI_NIB_LSB]            = aux_b; // RL1
				timer4_low_reload_d[`T4X_HI_NIB_MSB:`T4X_HI_NIB_LSB] = aux_b; // RL1
				timer4_d[`T4X_LO_NIB_MSB:`T4X_LO_NIB_LSB]            = acc; // RL2
				timer4_low_reload_d[`T4X_LO_NIB_MSB:`T4X_LO_NIB_LSB] = acc; // RL2
				timer4_loaded_d = 1'b1;
			end
			T4X_LOAD_HIGH_RELOAD: begin
				timer4_high_reload_d = {aux_b, acc}; // RL3
			end
			T4X_COPY_LOW_RELOAD_TO_TIMER: begin
				timer4_d        = timer4_low_reload_q; // RL4
				timer4_loaded_d = 1'b1;
			end
			T4X_COPY_AUX_TO_ACC: begin
				acc_we_d    = 1'b1; // RL5
				acc_wdata_d = aux_b; // RL5
			end
			default: begin
				done_d = 1'b0;
			end
		endcase
	end

	// Single cycle completion: results land on the edge closing the cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timer4_q             <= `T4X_TIMER_RST;
			timer4_low_reload_q  <= `T4X_RELOAD_RST;
			timer4_high_reload_q <= `T4X_RELOAD_RST;
			timer4_loaded_q      <= 1'b0;
			acc_we_q             <= 1'b0;
			acc_wdata_q          <= `T4X_NIB_RST;
			done_q               <= 1'b0;
			skip_next_q          <= 1'b0;
			carry_we_q           <= 1'b0;
		end else begin
			timer4_q             <= timer4_d;
			timer4_low_reload_q  <= timer4_low_reload_d;
			timer4_high_reload_q <= timer4_high_reload_d;
			timer4_loaded_q      <= timer4_loaded_d;
			acc_we_q             <= acc_we_d;
			acc_wdata_q          <= acc_wdata_d;
			done_q               <= done_d; // RL6
			skip_next_q          <= 1'b0; // RL6
			carry_we_q           <= 1'b0; // RL6
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic op_tlr;
	logic op_hr;
	logic op_cpy;
	logic op_ab;
	logic op_known;
	assign op_tlr = instr_valid && instr == `T4X_OP_LOAD_TLR;
	assign op_hr  = instr_valid && instr == `T4X_OP_LOAD_HR;
	assign op_cpy = instr_valid && instr == `T4X_OP_COPY_LR_T;
	assign op_ab  = instr_valid && instr == `T4X_OP_COPY_B_A;
	assign op_known = op_tlr || op_hr || op_cpy || op_ab;

	tlr_high_nib_a: assert property ( // RL1
		op_tlr |=> timer4_q[7:4] == $past(aux_b) && timer4_low_reload_q[7:4] == $past(aux_b))
		else $error("combined load high nibble wrong");

	tlr_low_nib_a: assert property ( // RL2
		op_tlr |=> timer4_q[3:0] == $past(acc) && timer4_low_reload_q[3:0] == $past(acc))
		else $error("combined load low nibble wrong");

	hr_load_a: assert property ( // RL3
		op_hr |=> timer4_high_reload_q == {$past(aux_b), $past(acc)}
			&& $stable(timer4_q) && $stable(timer4_low_reload_q))
		else $error("high reload load wrong");

	lr_copy_a: assert property ( // RL4
		op_cpy |=> timer4_q == $past(timer4_low_reload_q) && $stable(timer4_low_reload_q))
		else $error("reload to timer copy wrong");

	aux_to_acc_a: assert property ( // RL5
		op_ab |=> acc_we_q && acc_wdata_q == $past(aux_b) && $stable(timer4_q))
		else $error("aux to accumulator transfer wrong");

	one_cycle_a: assert property ( // RL6
		op_known |=> done_q)
		else $error("instruction not completed in one cycle");

	done_drop_a: assert property ( // RL6
		!op_known |=> !done_q)
		else $error("completion raised with no recognised instruction");

	no_side_a: assert property ( // RL6
		!skip_next_q && !carry_we_q)
		else $error("carry written or skip raised");

	idle_hold_a: assert property (
		!instr_valid |=> $stable(timer4_q) && $stable(timer4_high_reload_q) && !acc_we_q)
		else $error("state changed with no instruction");

	refused_a: assert property (
		instr_valid && !op_known |=> !done_q && !acc_we_q && !timer4_loaded_q
			&& $stable(timer4_q) && $stable(timer4_low_reload_q)
			&& $stable(timer4_high_reload_q) && $stable(acc_wdata_q))
		else $error("unrecognised instruction changed state");

	loaded_set_a: assert property ( // RL4
		(op_tlr || op_cpy) |=> timer4_loaded_q)
		else $error("timer write not flagged");

	loaded_clr_a: assert property ( // RL1
		!(op_tlr || op_cpy) |=> !timer4_loaded_q && $stable(timer4_q))
		else $error("timer written by another instruction");

	acc_hold_a: assert property ( // RL5
		!op_ab |=> !acc_we_q && $stable(acc_wdata_q))
		else $error("accumulator written by another instruction");

	hr_hold_a: assert property ( // RL3
		!op_hr |=> $stable(timer4_high_reload_q))
		else $error("high reload written by another instruction");

	lr_hold_a: assert property ( // RL4
		!op_tlr |=> $stable(timer4_low_reload_q))
		else $error("low reload written by another instruction");

	tlr_keep_a: assert property ( // RL2
		op_tlr |=> $stable(timer4_high_reload_q) && !acc_we_q)
		else $error("combined load touched other registers");

	cpy_keep_a: assert property ( // RL4
		op_cpy |=> $stable(timer4_high_reload_q) && !acc_we_q)
		else $error("reload to timer copy touched other registers");

	ab_keep_a: assert property ( // RL5
		op_ab |=> $stable(timer4_low_reload_q) && !timer4_loaded_q)
		else $error("aux to accumulator touched timer registers");

	// Held in reset for two edges, every output except skip_next_q and carry_we_q must sit at its reset value
	rst_values_a: assert property (@(posedge clk) disable iff (1'b0)
		!rstn ##1 !rstn |-> timer4_q == `T4X_TIMER_RST
			&& timer4_low_reload_q == `T4X_RELOAD_RST
			&& timer4_high_reload_q == `T4X_RELOAD_RST
			&& acc_wdata_q == `T4X_NIB_RST
			&& !acc_we_q && !timer4_loaded_q && !done_q)
		else $error("outputs not at reset values");

	tlr_cov: cover property (op_tlr ##1 op_cpy);
	hr_cov:  cover property (op_hr);
	ab_cov:  cover property (op_ab ##1 op_ab);
	seq_cov: cover property (op_tlr ##1 !instr_valid [*2] ##1 op_cpy);
	carry_cov: cover property (carry_flag && op_tlr);

endmodule

// ==== verif/tb_timer4_load_instr_exec.sv ====
// Self-checking bench for the timer 4 transfer executor
`timescale 1ns/10ps
`include "t4x_map.svh"

module tb_timer4_load_instr_exec;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        instr_valid = 1'b0;
	logic [9:0]  instr = 10'h000;
	logic [3:0]  acc = 4'h0;
	logic [3:0]  aux_b = 4'h0;
	logic        carry_flag = 1'b0;
	logic        acc_we_q, timer4_loaded_q, done_q, skip_next_q, carry_we_q;
	logic [3:0]  acc_wdata_q;
	logic [7:0]  timer4_q, timer4_low_reload_q, timer4_high_reload_q;
	int          failures = 0;
	int          num_checks = 0;
	logic [31:0] seed = 32'h7e486230;
	logic [7:0]  tm = 8'h00, lr = 8'h00, hr = 8'h00;
	logic [3:0]  wd = 4'h0;
	logic [32:0] expq[$];
	realtime     tq[$];
	wire [32:0]  seen_w;
	assign seen_w = {done_q, timer4_q, timer4_low_reload_q, timer4_high_reload_q,
		acc_we_q, acc_wdata_q, timer4_loaded_q, skip_next_q, carry_we_q};
	logic [9:0]  ops[6] = '{10'h233, 10'h237, 10'h297, 10'h01e, 10'h232, 10'h01f};

	always #2.5 clk = ~clk;

	t4x_exec dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
		.acc(acc), .aux_b(aux_b), .carry_flag(carry_flag), .acc_we_q(acc_we_q),
		.acc_wdata_q(acc_wdata_q), .timer4_q(timer4_q),
		.timer4_low_reload_q(timer4_low_reload_q),
		.timer4_high_reload_q(timer4_high_reload_q), .timer4_loaded_q(timer4_loaded_q),
		.done_q(done_q), .skip_next_q(skip_next_q), .carry_we_q(carry_we_q));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Drive one cycle and note the state expected after its edge
	task automatic issue(input logic [9:0] op, input logic v);
		logic we, ld, dn;
		seed = xs(seed);
		@(posedge clk);
		instr_valid <= v;
		instr       <= op;
		acc         <= seed[3:0];
		aux_b       <= seed[7:4];
		carry_flag  <= seed[8];
		we = 1'b0;
		ld = 1'b0;
		dn = v;
		if (v) case (op)
			`T4X_OP_LOAD_TLR: begin
				tm = seed[7:0];
				lr = seed[7:0];
				ld = 1'b1;
			end
			`T4X_OP_LOAD_HR: hr = seed[7:0];
			`T4X_OP_COPY_LR_T: begin
				tm = lr;
				ld = 1'b1;
			end
			`T4X_OP_COPY_B_A: begin
				wd = seed[7:4];
				we = 1'b1;
			end
			default: dn = 1'b0;
		endcase
		expq.push_back({dn, tm, lr, hr, we, wd, ld, 2'b00});
		tq.push_back($realtime);
	endtask

	// A note falls due at the falling edge half a clock after the edge that takes its instruction
	always @(negedge clk) begin
		if (rstn && tq.size() > 0 && $realtime - tq[0] > 5.0) begin
			check("state", seen_w, expq.pop_front());
			void'(tq.pop_front());
		end
	end

	initial begin
		logic [31:0] r;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		issue(10'h297, 1'b1);
		for (int i = 0; i < 6; i++)
			issue(ops[i], 1'b1);
		issue(10'h297, 1'b1);
		issue(10'h233, 1'b0);
		r = seed;
		for (int i = 0; i < 400; i++) begin
			r = xs(r);
			issue(r[2] ? ops[r[1:0]] : r[21:12], r[3] | r[4]);
		end
		issue(10'h000, 1'b0);
		repeat (3) @(negedge clk);
		check("drained", expq.size(), 33'h0);
		// Second reset in mid-run: outputs clear at once and the model restarts
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(negedge clk);
		check("in reset", seen_w, 33'h0);
		@(posedge clk);
		rstn <= 1'b1;
		tm = 8'h00;
		lr = 8'h00;
		hr = 8'h00;
		wd = 4'h0;
		issue(10'h297, 1'b1);
		issue(10'h01e, 1'b1);
		issue(10'h233, 1'b1);
		issue(10'h297, 1'b1);
		issue(10'h237, 1'b1);
		issue(10'h000, 1'b0);
		repeat (3) @(negedge clk);
		check("drained after reset", expq.size(), 33'h0);
		final_report();
	end

	initial begin
		#10000;
		failures++;
		final_report();
	end
endmodule
